// ===== core/eabm_pkg.sv
// Purpose: shared constants and carriers for the external async bus master
// Assumes: one bus phase (half a system clock) per core_clk cycle
// Notes: port width acknowledge pair is active low, bit 1 then bit 0
package eabm_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int OPND_W = 32;
  // acknowledge pair codes {ack1, ack0}, active low
  localparam logic [1:0] ACK_WAIT = 2'h3;
  localparam logic [1:0] ACK_BYTE = 2'h2;
  localparam logic [1:0] ACK_WORD = 2'h1;
  localparam logic [1:0] ACK_RSVD = 2'h0;
  // space codes
  localparam logic [2:0] SPACE_USER_DATA = 3'h1;
  localparam logic [2:0] SPACE_USER_PROG = 3'h2;
  localparam logic [2:0] SPACE_SUPV_DATA = 3'h5;
  localparam logic [2:0] SPACE_SUPV_PROG = 3'h6;
  localparam logic [2:0] SPACE_CPU = 3'h7;
  // operand lengths in bytes; the size code is the low two bits of what remains
  localparam logic [2:0] BYTES_BYTE = 3'h1;
  localparam logic [2:0] BYTES_WORD = 3'h2;
  localparam logic [2:0] BYTES_LONG = 3'h4;
  localparam logic [2:0] BYTES_ONE = 3'h1;
  localparam logic [2:0] BYTES_TWO = 3'h2;
  // bus monitor timeout, counted in phases
  localparam int MONITOR_CLOCKS = 64;
  localparam int PHASES_PER_CLOCK = 2;
  localparam int MON_W = 8;
  localparam logic [MON_W-1:0] MONITOR_LAST = MON_W'(MONITOR_CLOCKS * PHASES_PER_CLOCK - 1);
  localparam logic [MON_W-1:0] MON_ONE = 8'h01;

  typedef struct packed {
    logic start;
    logic write;
    logic [2:0] bytes;
    logic intAck;
    logic [2:0] space;
    logic [ADDR_W-1:0] addr;
    logic [OPND_W-1:0] wdata;
  } eabm_req_t;

  typedef struct packed {
    logic done;
    logic fault;
    logic autovec;
    logic [OPND_W-1:0] rdata;
  } eabm_rsp_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [2:0] space;
    logic [1:0] sizeCode;
    logic readWrite;
    logic addressStrobeN;
    logic dataStrobeN;
  } eabm_ctl_t;
endpackage

// ===== core/eabm_master.sv
// Purpose: master end of the external asynchronous bus with dynamic sizing
// Assumes: each core_clk cycle is one half-clock bus phase; inputs synchronous
// Notes: a bus cycle is phases T0..T5; wait states stretch T3
`timescale 1ns/1ps
`default_nettype none
module eabm_master
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire eabm_pkg::eabm_req_t req,
  output logic reqReady,
  output eabm_pkg::eabm_rsp_t rsp,
  output eabm_pkg::eabm_ctl_t busCtl,
  input wire logic [eabm_pkg::DATA_W-1:0] dataIn,
  output logic [eabm_pkg::DATA_W-1:0] dataOut,
  output logic dataOe,
  input wire logic [1:0] port_width_ack_n,
  input wire logic [1:0] csPortWidthAckN,
  input wire logic bus_fault_n,
  input wire logic suspendReqN,
  input wire logic autovector_request_n,
  input wire logic csAutovectorN,
  input wire logic monitorEnable,
  input wire logic outsideMaster,
  output logic suspended
);
  typedef enum logic [2:0] {IDLE, T0, T1, T2, T3, T4, T5, HOLD} eabm_state_t;

  eabm_state_t state_q;
  eabm_pkg::eabm_ctl_t ctl_q;
  logic [eabm_pkg::OPND_W-1:0] opnd_q;
  logic [2:0] remain_q;
  logic write_q, intAck_q, faulted_q, autovec_q, two_q, wide_q, retry_q;
  logic [eabm_pkg::MON_W-1:0] mon_q;
  logic [eabm_pkg::DATA_W-1:0] dataOut_q;
  logic dataOe_q, reqReady_q, suspended_q;
  eabm_pkg::eabm_rsp_t rsp_q;

  logic [1:0] ackN;
  logic ackValid, autovecOk, monTimeout, faultIn, terminate, twoNow, moreBytes;
  logic [7:0] byteSel;
  logic [2:0] step;

  ////////////////////////////////////////////////////////////////////////////
  // termination decode
  // chip-select acknowledge merges with the pins as a wired-low pair
  assign ackN = port_width_ack_n & csPortWidthAckN;
  // the reserved code is treated as a wait so the monitor catches it
  assign ackValid = (ackN == eabm_pkg::ACK_BYTE) || (ackN == eabm_pkg::ACK_WORD);
  assign autovecOk = intAck_q && (ctl_q.space == eabm_pkg::SPACE_CPU) && !outsideMaster
    && !(autovector_request_n & csAutovectorN);
  assign monTimeout = monitorEnable && !outsideMaster && (mon_q == eabm_pkg::MONITOR_LAST);
  assign faultIn = !bus_fault_n || monTimeout;
  assign terminate = ackValid || autovecOk || faultIn;
  // a 16-bit port moves two bytes only from an even address
  assign twoNow = (ackN == eabm_pkg::ACK_WORD) && !ctl_q.addr[0]
    && (remain_q >= eabm_pkg::BYTES_TWO);
  assign step = two_q ? eabm_pkg::BYTES_TWO : eabm_pkg::BYTES_ONE;
  // 8-bit ports and even bytes use the upper lane
  assign byteSel = (wide_q && ctl_q.addr[0]) ? dataIn[7:0] : dataIn[15:8];
  assign moreBytes = (remain_q != 3'h0) && !autovec_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_q <= IDLE;
      ctl_q <= '{addr: 24'h000000, space: 3'h0, sizeCode: 2'h0, readWrite: 1'b1,
                 addressStrobeN: 1'b1, dataStrobeN: 1'b1};
      remain_q <= 3'h0;
      write_q <= 1'b0;
      intAck_q <= 1'b0;
      faulted_q <= 1'b0;
      autovec_q <= 1'b0;
      two_q <= 1'b0;
      wide_q <= 1'b0;
      retry_q <= 1'b0;
      suspended_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        IDLE:
        begin
          if (req.start)
          begin
            // address, space, size and direction go out at cycle start
            ctl_q.addr <= req.addr;
            ctl_q.space <= req.space;
            ctl_q.sizeCode <= req.bytes[1:0];
            ctl_q.readWrite <= !req.write;
            remain_q <= req.bytes;
            write_q <= req.write;
            intAck_q <= req.intAck;
            autovec_q <= 1'b0;
            faulted_q <= 1'b0;
            state_q <= T0;
          end
        end
        T0:
        begin
          ctl_q.addressStrobeN <= 1'b0;
          ctl_q.dataStrobeN <= write_q;
          state_q <= T1;
        end
        T1:
          state_q <= T2;
        T2:
        begin
          ctl_q.dataStrobeN <= 1'b0;
          state_q <= T3;
        end
        T3:
        begin
          if (terminate)
          begin
            faulted_q <= faultIn;
            autovec_q <= autovecOk && !faultIn;
            two_q <= twoNow;
            wide_q <= ackN == eabm_pkg::ACK_WORD;
            state_q <= T4;
          end
        end
        T4:
        begin
          ctl_q.addressStrobeN <= 1'b1;
          ctl_q.dataStrobeN <= 1'b1;
          if (!faulted_q)
          begin
            remain_q <= remain_q - step;
          end
          state_q <= T5;
        end
        T5:
        begin
          if (!suspendReqN)
          begin
            // suspend: strobes stay high, outputs kept as they are
            retry_q <= faulted_q;
            suspended_q <= 1'b1;
            state_q <= HOLD;
          end
          else if (!faulted_q && moreBytes)
          begin
            ctl_q.addr <= ctl_q.addr + eabm_pkg::ADDR_W'(step);
            ctl_q.sizeCode <= remain_q[1:0];
            state_q <= T0;
          end
          else
          begin
            state_q <= IDLE;
          end
        end
        HOLD:
        begin
          if (suspendReqN)
          begin
            suspended_q <= 1'b0;
            faulted_q <= 1'b0;
            if (retry_q)
            begin
              // rerun the faulted cycle with the very same outputs
              state_q <= T0;
            end
            else if (moreBytes)
            begin
              ctl_q.addr <= ctl_q.addr + eabm_pkg::ADDR_W'(step);
              ctl_q.sizeCode <= remain_q[1:0];
              state_q <= T0;
            end
            else
            begin
              state_q <= IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand shifter and write data drive
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      opnd_q <= 32'h00000000;
      dataOut_q <= 16'h0000;
      dataOe_q <= 1'b0;
    end
    else
    begin
      if (state_q == IDLE && req.start)
      begin
        // left-justify write operands so the next byte is always on top
        unique case (req.bytes)
          eabm_pkg::BYTES_BYTE: opnd_q <= {req.wdata[7:0], 24'h000000};
          eabm_pkg::BYTES_WORD: opnd_q <= {req.wdata[15:0], 16'h0000};
          default: opnd_q <= req.wdata;
        endcase
      end
      else if (state_q == T4 && !faulted_q && !autovec_q)
      begin
        if (write_q)
        begin
          opnd_q <= two_q ? {opnd_q[15:0], 16'h0000} : {opnd_q[23:0], 8'h00};
        end
        else
        begin
          // end of T4, as the strobes rise: read data comes in right-justified
          opnd_q <= two_q ? {opnd_q[15:0], dataIn} : {opnd_q[23:0], byteSel};
        end
      end
      if (state_q == T1 && write_q)
      begin
        // an odd byte is mirrored so any port width sees it
        // every cycle starts as if the port were 16 bits wide
        dataOut_q <= ctl_q.addr[0] ? {2{opnd_q[31:24]}} : opnd_q[31:16];
        dataOe_q <= 1'b1;
      end
      else if (state_q == T4)
      begin
        dataOe_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus monitor: restarts on every cycle, so long byte streams never trip it
  always_ff @(posedge core_clk)
  begin
    if (!nrst || state_q == T0)
    begin
      mon_q <= '0;
    end
    else if (state_q == T3 && !monTimeout)
    begin
      mon_q <= mon_q + eabm_pkg::MON_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response to the core
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      rsp_q <= '0;
      reqReady_q <= 1'b0;
    end
    else
    begin
      rsp_q.done <= 1'b0;
      reqReady_q <= (state_q == IDLE) && !req.start;
      if ((state_q == T5 && suspendReqN && (faulted_q || !moreBytes))
          || (state_q == HOLD && suspendReqN && !retry_q && !moreBytes))
      begin
        rsp_q.done <= 1'b1;
        rsp_q.fault <= faulted_q;
        rsp_q.autovec <= autovec_q;
        rsp_q.rdata <= opnd_q;
      end
    end
  end

  assign busCtl = ctl_q;
  assign dataOut = dataOut_q;
  assign dataOe = dataOe_q;
  assign rsp = rsp_q;
  assign reqReady = reqReady_q;
  assign suspended = suspended_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence strobeFall;
    $fell(busCtl.addressStrobeN);
  endsequence
  // write data strobe follows the address strobe by two phases
  sequence writeStrobeLate;
    busCtl.dataStrobeN ##1 busCtl.dataStrobeN ##1 !busCtl.dataStrobeN;
  endsequence

  addr_hold_a: assert property (!busCtl.addressStrobeN && $past(!busCtl.addressStrobeN)
    |-> $stable(busCtl.addr) && $stable(busCtl.space) && $stable(busCtl.sizeCode))
    else $error("address moved under strobe");
  strobe_launch_a: assert property (state_q == T0 |=> strobeFall)
    else $error("address strobe late");
  read_strobe_a: assert property (strobeFall and busCtl.readWrite |-> $fell(busCtl.dataStrobeN))
    else $error("read data strobe not with address strobe");
  write_strobe_a: assert property (strobeFall and !busCtl.readWrite |-> writeStrobeLate)
    else $error("write data strobe timing");
  write_data_a: assert property (strobeFall and !busCtl.readWrite |-> !dataOe ##1 dataOe)
    else $error("write data timing");
  rw_change_a: assert property ($changed(busCtl.readWrite) |-> state_q == T0)
    else $error("direction changed mid cycle");
  size_code_a: assert property (state_q == T0 |-> busCtl.sizeCode == remain_q[1:0])
    else $error("size code wrong");
  hold_float_a: assert property (state_q == HOLD |-> busCtl.addressStrobeN
    && busCtl.dataStrobeN && !dataOe && $stable(busCtl.addr))
    else $error("suspend outputs wrong");
  three_clock_a: assert property (state_q == T3 && ackValid && !faultIn
    |=> ##1 busCtl.addressStrobeN ##1 (state_q == T0 || state_q == IDLE || state_q == HOLD))
    else $error("cycle length wrong");
  autovec_ignore_a: assert property (state_q == T3 && !intAck_q && ackN == eabm_pkg::ACK_WAIT
    && !faultIn |=> state_q == T3)
    else $error("autovector ended a normal cycle");
endmodule // eabm_master
`default_nettype wire

// ===== verif/eabm_mem_model.sv
// Purpose: behavioural memory or peripheral on the far side of the external bus
// Assumes: only the low address byte is decoded; the bench preloads mem
// Notes: a waitCnt of 8'hff never acknowledges, so such cycles end only by fault, autovector or bypass
`timescale 1ns/1ps
`default_nettype none
module eabm_mem_model
(
  input wire logic core_clk,
  input wire eabm_pkg::eabm_ctl_t busCtl,
  input wire logic [15:0] dataOut,
  input wire logic port8,
  input wire logic [7:0] waitCnt,
  output logic [15:0] dataIn,
  output logic [1:0] ackN
);
  logic [7:0] mem [0:255];
  logic [7:0] cnt = 8'h00;
  logic [7:0] a;
  assign a = busCtl.addr[7:0];
  // acknowledge only while data strobe is low; otherwise the idle code
  assign ackN = (!busCtl.dataStrobeN && cnt > waitCnt) ? (port8 ? eabm_pkg::ACK_BYTE : eabm_pkg::ACK_WORD)
    : eabm_pkg::ACK_WAIT;
  initial dataIn = 16'h0000;
  always @(posedge core_clk)
  begin
    cnt <= busCtl.dataStrobeN ? 8'h00 : (cnt == 8'hff ? cnt : cnt + 8'h01);
    // released lines toggle so a stale value never looks valid
    if (busCtl.readWrite && !busCtl.dataStrobeN)
      dataIn <= port8 ? {mem[a], ~mem[a]} : {mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}]};
    else
      dataIn <= ~dataIn;
    if (!busCtl.readWrite && !busCtl.dataStrobeN && ackN != eabm_pkg::ACK_WAIT)
    begin
      if (port8)
        mem[a] <= dataOut[15:8];
      else if (a[0])
        mem[a] <= dataOut[7:0];
      else
      begin
        mem[a] <= dataOut[15:8];
        if (busCtl.sizeCode != 2'h1)
          mem[a + 8'h01] <= dataOut[7:0];
      end
    end
  end
endmodule // eabm_mem_model
`default_nettype wire

// ===== verif/testbench.sv
// Purpose: self-checking bench for the external bus master
// Assumes: bench drives at the falling edge; far side is eabm_mem_model
// Notes: expected bus cycles are worked out from each request; expected data comes from a reference byte array
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  eabm_pkg::eabm_req_t req = '0;
  eabm_pkg::eabm_rsp_t rsp;
  eabm_pkg::eabm_ctl_t busCtl;
  logic reqReady, dataOe, suspended, rwLast;
  logic [15:0] dataIn, dataOut;
  logic [1:0] ackN;
  logic [1:0] csAckN = 2'h3;
  logic faultN = 1'b1, suspN = 1'b1, autovecN = 1'b1, csAutovecN = 1'b1, monEn = 1'b1, outside = 1'b0;
  logic port8 = 1'b0, csMode = 1'b0;
  logic [7:0] waitCnt = 8'h00;
  logic [7:0] refMem [0:255];
  logic [29:0] seen [$];
  logic [2:0] spaces [5] = '{eabm_pkg::SPACE_USER_DATA, eabm_pkg::SPACE_USER_PROG, eabm_pkg::SPACE_SUPV_DATA,
    eabm_pkg::SPACE_SUPV_PROG, eabm_pkg::SPACE_CPU};
  logic [31:0] r;
  logic [2:0] nb;
  logic [23:0] ad;
  int error_cnt = 0, checks = 0, seed = 93, strobeAge = 0, n = 0;
  always #25 core_clk = ~core_clk;
  eabm_master dut_u (.core_clk(core_clk), .nrst(nrst), .req(req), .reqReady(reqReady), .rsp(rsp), .busCtl(busCtl),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .port_width_ack_n(ackN), .csPortWidthAckN(csAckN),
    .bus_fault_n(faultN), .suspendReqN(suspN), .autovector_request_n(autovecN), .csAutovectorN(csAutovecN),
    .monitorEnable(monEn), .outsideMaster(outside), .suspended(suspended));
  eabm_mem_model mem_u (.core_clk(core_clk), .busCtl(busCtl), .dataOut(dataOut), .port8(port8), .waitCnt(waitCnt),
    .dataIn(dataIn), .ackN(ackN));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chkv({31'h0, got}, {31'h0, exp});
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // chip-select bypass answers as a 16-bit port once data strobe is low
  always @(negedge core_clk)
    csAckN <= (csMode && !busCtl.dataStrobeN) ? eabm_pkg::ACK_WORD : eabm_pkg::ACK_WAIT;
  // per bus cycle: record outputs at strobe assertion and watch strobe spacing
  always @(posedge core_clk)
  begin
    #1;
    if (nrst && !busCtl.addressStrobeN)
    begin
      strobeAge++;
      if (strobeAge == 1)
        seen.push_back({busCtl.space, busCtl.addr, busCtl.sizeCode, busCtl.readWrite});
      if (strobeAge < 3)
        chkb(busCtl.dataStrobeN, !busCtl.readWrite);
      if (strobeAge == 3 && !busCtl.readWrite)
        chkb(busCtl.dataStrobeN, 1'b0);
      if (strobeAge >= 2 && !busCtl.readWrite)
        chkb(dataOe, 1'b1);
      if (strobeAge > 1)
        chkb(busCtl.readWrite, rwLast);
    end
    else
      strobeAge = 0;
    rwLast = busCtl.readWrite;
  end
  // called and left at a falling edge
  task automatic xfer(input logic wr, input logic [2:0] nb, input logic [23:0] ad, input logic [2:0] sp,
    input logic ia, input logic [31:0] wd, input logic expF, input logic expAv);
    int n;
    int k;
    logic [23:0] a;
    logic [2:0] rem;
    logic [31:0] exp;
    logic [7:0] b;
    n = 0;
    k = 0;
    exp = 32'h0;
    seen.delete();
    while (reqReady !== 1'b1 && n < 50)
    begin
      @(negedge core_clk);
      n++;
    end
    req = '{1'b1, wr, nb, ia, sp, ad, wd};
    @(negedge core_clk);
    req.start = 1'b0;
    n = 0;
    while (rsp.done !== 1'b1 && n < 400)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chkb(rsp.done, 1'b1);
    chkb(rsp.fault, expF);
    chkb(rsp.autovec, expAv);
    if (!expF && !expAv)
    begin
      a = ad;
      rem = nb;
      while (rem != 3'h0)
      begin
        chkv(32'(seen[k]), {2'h0, sp, a, rem[1:0], !wr});
        if (!port8 && !a[0] && rem >= 3'h2)
        begin
          a += 24'h2;
          rem -= 3'h2;
        end
        else
        begin
          a += 24'h1;
          rem -= 3'h1;
        end
        k++;
      end
      chkv(seen.size(), k);
      for (int i = 0; i < int'(nb); i++)
      begin
        b = ad[7:0] + 8'(i);
        if (wr)
        begin
          refMem[b] = wd[8 * (int'(nb) - 1 - i) +: 8];
          chkv({24'h0, mem_u.mem[b]}, {24'h0, refMem[b]});
        end
        else
          exp = {exp[23:0], refMem[b]};
      end
      if (!wr)
        chkv(rsp.rdata, exp);
    end
    @(negedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #2000000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      refMem[i] = 8'($random(seed));
      mem_u.mem[i] = refMem[i];
    end
    repeat (3) @(posedge core_clk);
    #1;
    chkb(busCtl.addressStrobeN & busCtl.dataStrobeN & busCtl.readWrite, 1'b1);
    chkb(dataOe | reqReady, 1'b0);
    @(negedge core_clk);
    nrst = 1'b1;
    // long operand through an 8-bit port, wrapping the low address byte
    port8 = 1'b1;
    waitCnt = 8'h02;
    xfer(1'b1, eabm_pkg::BYTES_LONG, 24'h0001fe, eabm_pkg::SPACE_SUPV_DATA, 1'b0, 32'ha5c3_1e07, 1'b0, 1'b0);
    xfer(1'b0, eabm_pkg::BYTES_LONG, 24'h0001fe, eabm_pkg::SPACE_SUPV_PROG, 1'b0, 32'h0, 1'b0, 1'b0);
    for (int i = 0; i < 40; i++)
    begin
      r = $random(seed);
      port8 = r[0];
      waitCnt = {6'h0, r[2:1]};
      nb = r[4:3] == 2'h0 ? eabm_pkg::BYTES_BYTE : (r[4:3] == 2'h1 ? eabm_pkg::BYTES_WORD : eabm_pkg::BYTES_LONG);
      ad = {8'h0, r[31:17], r[16] & (nb == eabm_pkg::BYTES_BYTE)};
      xfer(r[5], nb, ad, spaces[i % 5], 1'b0, $random(seed), 1'b0, 1'b0);
    end
    port8 = 1'b0;
    waitCnt = 8'hff;
    csMode = 1'b1;
    xfer(1'b0, eabm_pkg::BYTES_WORD, 24'h000020, eabm_pkg::SPACE_USER_PROG, 1'b0, 32'h0, 1'b0, 1'b0);
    csMode = 1'b0;
    // silent far end: the monitor must end the cycle
    xfer(1'b0, eabm_pkg::BYTES_WORD, 24'h000022, eabm_pkg::SPACE_USER_DATA, 1'b0, 32'h0, 1'b1, 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      autovecN = j[0];
      csAutovecN = !j[0];
      xfer(1'b0, eabm_pkg::BYTES_BYTE, 24'h000003, eabm_pkg::SPACE_CPU, 1'b1, 32'h0, 1'b0, 1'b1);
      xfer(1'b0, eabm_pkg::BYTES_BYTE, 24'h000003, eabm_pkg::SPACE_CPU, 1'b0, 32'h0, 1'b1, 1'b0);
    end
    autovecN = 1'b1;
    csAutovecN = 1'b1;
    // fault held from the start: it ends the cycle in the first T3 phase and wins over the acknowledge already present
    waitCnt = 8'h00;
    faultN = 1'b0;
    xfer(1'b0, eabm_pkg::BYTES_WORD, 24'h000030, eabm_pkg::SPACE_USER_DATA, 1'b0, 32'h0, 1'b1, 1'b0);
    faultN = 1'b1;
    waitCnt = 8'hff;
    outside = 1'b1;
    fork
      xfer(1'b1, eabm_pkg::BYTES_WORD, 24'h000010, eabm_pkg::SPACE_USER_DATA, 1'b0, 32'h1234, 1'b1, 1'b0);
      begin
        repeat (150) @(negedge core_clk);
        chkb(busCtl.addressStrobeN, 1'b0);
        faultN = 1'b0;
        @(posedge rsp.done);
        @(negedge core_clk);
        faultN = 1'b1;
      end
    join
    outside = 1'b0;
    waitCnt = 8'h00;
    suspN = 1'b0;
    fork
      xfer(1'b0, eabm_pkg::BYTES_LONG, 24'h000040, eabm_pkg::SPACE_SUPV_DATA, 1'b0, 32'h0, 1'b0, 1'b0);
      begin
        while (suspended !== 1'b1 && n < 100)
        begin
          @(posedge core_clk);
          #1;
          n++;
        end
        repeat (8) @(posedge core_clk);
        #1;
        chkb(suspended, 1'b1);
        chkb(busCtl.addressStrobeN & busCtl.dataStrobeN & !dataOe, 1'b1);
        chkv({8'h0, busCtl.addr}, 32'h000040);
        @(negedge core_clk);
        suspN = 1'b1;
      end
    join
    // fault during suspend: the same cycle runs again after release
    faultN = 1'b0;
    suspN = 1'b0;
    n = 0;
    fork
      xfer(1'b0, eabm_pkg::BYTES_BYTE, 24'h000051, eabm_pkg::SPACE_USER_DATA, 1'b0, 32'h0, 1'b1, 1'b0);
      begin
        while (suspended !== 1'b1 && n < 100)
        begin
          @(posedge core_clk);
          #1;
          n++;
        end
        chkb(suspended, 1'b1);
        @(negedge core_clk);
        suspN = 1'b1;
      end
    join
    faultN = 1'b1;
    chkv(seen.size(), 32'h00000002);
    chkv(32'(seen[1]), {2'h0, eabm_pkg::SPACE_USER_DATA, 24'h000051, 2'h1, 1'b1});
    close_out();
  end
endmodule // testbench
`default_nettype wire
